// ==== verilog/bgm_consts.svh ====
// Constants for the beam guard muting control: offsets, fields, reset values
// How it works
// R1: Five receiver elements, fed by three alternating beams, are each an interruption input with its own mute bit.
// R2: Any interrupted element that is not muted opens the safety outputs and stops the closing stroke.
// R3: A closing stroke may start only while all five elements see their beam, or both bending-line elements when box bending is armed.
// R4: On pedal press the adjustment element must see its pulse before release, and is then muted for the stroke.
// R5: The folding-stage indication mutes every element.
// R6: Releasing the box-bending button arms box bending, which mutes both lateral elements and the adjustment element.
// R7: The yellow lamp is lit for as long as box bending is armed.
// R8: With box bending armed, both bending-line elements stay monitored until the folding stage mutes everything.
// R9: Box bending is cancelled when the bend it was armed for has finished.
// R10: With box bending armed, the adjustment element is not checked at stroke start.
// R11: In box bending the machine control drops to a safe slow speed once the guard sits on its stops.
// R12: An internal fault puts the block into the safe state with its outputs open.
// R13: After power-up the outputs stay blocked until the start input has been closed and opened again.
// R14: Once a beam interruption clears, the outputs are not released again by themselves.
// R15: Before every release the load feedback must show the relays or valves dropped out, or release is refused.
// R16: Pedal, button and folding-stage inputs are synchronised levels; the button release is a falling edge.
// R17: Every stroke end clears all muting so the next stroke starts with all five elements monitored.
`ifndef BGM_CONSTS_SVH
`define BGM_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define BGM_REG_CTRL       4'h0
`define BGM_REG_STATUS     4'h4
`define BGM_REG_ELEM       4'h8
`define BGM_REG_TRIPS      4'hC

// ==========================================================================
// Field positions
`define BGM_CTRL_BOX_REQ   0
`define BGM_CTRL_FAULT_SET 1
`define BGM_STAT_SAFE      0
`define BGM_STAT_BOX       1
`define BGM_STAT_FAULT     2
`define BGM_STAT_FEEDBACK  3
`define BGM_STAT_STATE_LSB 8
`define BGM_ELEM_MUTE_LSB  8

// ==========================================================================
// Element masks and reset values
`define BGM_MASK_NONE      5'h00
`define BGM_MASK_ADJUST    5'h10
`define BGM_MASK_BOX       5'h1C
`define BGM_MASK_ALL       5'h1F
`define BGM_RST_WORD       32'h0000_0000
`define BGM_RST_TRIPS      16'h0000

`endif

// ==== verilog/bgm_pkg.sv ====
// Types shared by the beam guard muting control
package bgm_pkg;

  // ==========================================================================
  // Element vector: bit 0 bending_line_element_a, 1 bending_line_element_b,
  // 2 lateral_element_a, 3 lateral_element_b, 4 adjustment_check_element
  localparam int BGM_ELEMS = 5;
  typedef logic [BGM_ELEMS-1:0] bgm_elem_t;

  // ==========================================================================
  // Guard states, one-hot
  typedef enum logic [6:0] {
    BGM_ST_LOCK   = 7'h01,
    BGM_ST_ARM    = 7'h02,
    BGM_ST_IDLE   = 7'h04,
    BGM_ST_STROKE = 7'h08,
    BGM_ST_FOLD   = 7'h10,
    BGM_ST_TRIP   = 7'h20,
    BGM_ST_FAULT  = 7'h40
  } bgm_state_t;

endpackage

// ==== verilog/bgm_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps

module bgm_sync #(
  parameter int        WIDTH    = 1,
  parameter bit        RST_VAL  = 1'b0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // One pair of flops per bit; first stage is read by the second only
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          meta_r <= RST_VAL;
          hold_r <= RST_VAL;
        end
        else if (ce_in)
        begin
          meta_r <= async_in[gi];
          hold_r <= meta_r;
        end
      end
      assign sync_out[gi] = hold_r;
    end
  endgenerate

endmodule // bgm_sync

// ==== verilog/bgm_guard.sv ====
// Beam guard muting control: stroke sequencing, muting and register slave
`timescale 1ns/1ps
`include "bgm_consts.svh"

module bgm_guard #(
  parameter int ADR_W = 4
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire bgm_pkg::bgm_elem_t elem_clear_in,
  input  wire logic              pedal_in,
  input  wire logic              box_button_in,
  input  wire logic              fold_stage_in,
  input  wire logic              start_in,
  input  wire logic              load_dropped_in,
  input  wire logic              fault_in,
  output logic                   safety_release_out,
  output logic                   box_lamp_out,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADR_W-1:0]  wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out
);
  import bgm_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  bgm_elem_t elem_s;
  logic      pedal_s;
  logic      button_s;
  logic      fold_s;
  logic      start_s;
  logic      dropped_s;
  logic      fault_s;

  // Reset value 0 reads every beam as cut, so nothing releases early
  bgm_sync #(
    .WIDTH   (BGM_ELEMS + 6),
    .RST_VAL (1'b0)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in ({fault_in, load_dropped_in, start_in, fold_stage_in,
                box_button_in, pedal_in, elem_clear_in}),
    .sync_out ({fault_s, dropped_s, start_s, fold_s,
                button_s, pedal_s, elem_s})
  ); // [R16]

  // ==========================================================================
  // Decoding
  // Interrupted element that is not muted
  function automatic logic live_cut(input bgm_elem_t clear, input bgm_elem_t mute);
    live_cut = |(~clear & ~mute);
  endfunction

  // Mask each state may hold; any other value means a flipped bit
  function automatic logic mute_ok(input bgm_state_t st, input bgm_elem_t m);
    case (st)
      BGM_ST_STROKE:
        mute_ok = (m == `BGM_MASK_ADJUST) || (m == `BGM_MASK_BOX);
      BGM_ST_FOLD:
        mute_ok = (m == `BGM_MASK_ALL);
      default:
        mute_ok = (m == `BGM_MASK_NONE);
    endcase
  endfunction

  // ==========================================================================
  // Guard state
  bgm_state_t state_r;
  bgm_state_t state_nxt;
  bgm_elem_t  mute_r;
  bgm_elem_t  mute_nxt;
  logic       box_r;
  logic       box_nxt;
  logic       safe_r;
  logic       safe_nxt;
  logic       button_prev_r;
  logic       pedal_prev_r;
  logic [15:0] trips_r;
  logic [15:0] trips_nxt;
  logic       fault_set_r;
  logic       box_sw_req;
  logic       box_req;
  logic       pedal_rise;
  logic       start_ok;

  always_comb
  begin
    state_nxt  = state_r;
    mute_nxt   = mute_r;
    box_nxt    = box_r;
    trips_nxt  = trips_r;
    box_req    = (button_prev_r & ~button_s) | box_sw_req; // [R16] [R6]
    pedal_rise = pedal_s & ~pedal_prev_r;
    // Box bending only checks the bending line; adjustment check skipped
    start_ok   = box_r ? !live_cut(elem_s, `BGM_MASK_BOX)       // [R10]
                       : !live_cut(elem_s, `BGM_MASK_NONE);     // [R3] [R4]
    unique case (state_r)
      BGM_ST_LOCK:
      begin
        mute_nxt = `BGM_MASK_NONE;
        if (start_s)
          state_nxt = BGM_ST_ARM;                                // [R13]
      end
      BGM_ST_ARM:
      begin
        mute_nxt = `BGM_MASK_NONE;
        if (!start_s)
          state_nxt = BGM_ST_IDLE;                               // [R13]
      end
      BGM_ST_IDLE:
      begin
        mute_nxt = `BGM_MASK_NONE;                               // [R17]
        if (box_req)
          box_nxt = 1'b1;                                        // [R6]
        // Edge, not level: a held pedal never restarts after a cut
        if (pedal_rise && start_ok && dropped_s)                 // [R15] [R3]
        begin
          state_nxt = BGM_ST_STROKE;
          mute_nxt  = box_r ? `BGM_MASK_BOX : `BGM_MASK_ADJUST;  // [R4] [R6] [R8]
        end
      end
      BGM_ST_STROKE:
      begin
        if (fold_s)
        begin
          state_nxt = BGM_ST_FOLD;
          mute_nxt  = `BGM_MASK_ALL;                             // [R5] [R8]
        end
        else if (live_cut(elem_s, mute_r))                       // [R2] [R1]
        begin
          state_nxt = BGM_ST_TRIP;
          mute_nxt  = `BGM_MASK_NONE;
          // Saturate: a wrapped count would read as a quiet machine
          if (trips_r != 16'hFFFF)
            trips_nxt = trips_r + 16'h0001;
        end
        else if (!pedal_s)
        begin
          state_nxt = BGM_ST_IDLE;
          mute_nxt  = `BGM_MASK_NONE;                            // [R17]
        end
      end
      BGM_ST_FOLD:
      begin
        // Pedal release ends the bend; box request is spent
        if (!pedal_s)
        begin
          state_nxt = BGM_ST_IDLE;
          mute_nxt  = `BGM_MASK_NONE;                            // [R17]
          box_nxt   = 1'b0;                                      // [R9]
        end
      end
      BGM_ST_TRIP:
      begin
        mute_nxt = `BGM_MASK_NONE;
        // Only a start close/open cycle rearms; beam clearing alone does not
        if (start_s)
          state_nxt = BGM_ST_ARM;                                // [R14]
      end
      BGM_ST_FAULT:
      begin
        mute_nxt = `BGM_MASK_NONE;
        box_nxt  = 1'b0;
      end
      default:
      begin
        state_nxt = BGM_ST_FAULT;                                // [R12]
        mute_nxt  = `BGM_MASK_NONE;
      end
    endcase
    if (fault_s || fault_set_r || !mute_ok(state_r, mute_r))
    begin
      state_nxt = BGM_ST_FAULT;                                  // [R12]
      mute_nxt  = `BGM_MASK_NONE;
      box_nxt   = 1'b0;
    end
    safe_nxt = (state_nxt == BGM_ST_STROKE) || (state_nxt == BGM_ST_FOLD); // [R2] [R12]
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r       <= BGM_ST_LOCK;                              // [R13]
      mute_r        <= `BGM_MASK_NONE;
      box_r         <= 1'b0;
      safe_r        <= 1'b0;
      button_prev_r <= 1'b0;
      pedal_prev_r  <= 1'b1;
      trips_r       <= `BGM_RST_TRIPS;
    end
    else if (ce_in)
    begin
      state_r       <= state_nxt;
      mute_r        <= mute_nxt;
      box_r         <= box_nxt;
      safe_r        <= safe_nxt;
      button_prev_r <= button_s;
      pedal_prev_r  <= pedal_s;
      trips_r       <= trips_nxt;
    end
  end

  assign safety_release_out = safe_r;
  assign box_lamp_out       = box_r;                             // [R7]

  // ==========================================================================
  // Wishbone slave: one wait state, unmapped reads return zero
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        fault_set_nxt;
  logic        wr_ctrl;

  always_comb
  begin
    ack_nxt       = wb_cyc_in & wb_stb_in & ~ack_r;
    dat_nxt       = dat_r;
    fault_set_nxt = fault_set_r;
    wr_ctrl       = ack_nxt & wb_we_in & wb_sel_in[0] &
                    (wb_adr_in == ADR_W'(`BGM_REG_CTRL));
    box_sw_req    = wr_ctrl & wb_dat_in[`BGM_CTRL_BOX_REQ];
    // Sticky until reset: a forced fault cannot be cleared by software
    if (wr_ctrl && wb_dat_in[`BGM_CTRL_FAULT_SET])
      fault_set_nxt = 1'b1;                                      // [R12]
    if (ack_nxt && !wb_we_in)
    begin
      dat_nxt = `BGM_RST_WORD;
      unique case (wb_adr_in)
        ADR_W'(`BGM_REG_CTRL):
          dat_nxt[`BGM_CTRL_FAULT_SET] = fault_set_r;
        ADR_W'(`BGM_REG_STATUS):
        begin
          dat_nxt[`BGM_STAT_SAFE]     = safe_r;
          dat_nxt[`BGM_STAT_BOX]      = box_r;
          dat_nxt[`BGM_STAT_FAULT]    = (state_r == BGM_ST_FAULT);
          dat_nxt[`BGM_STAT_FEEDBACK] = dropped_s;
          dat_nxt[`BGM_STAT_STATE_LSB +: 7] = state_r;
        end
        ADR_W'(`BGM_REG_ELEM):
        begin
          dat_nxt[BGM_ELEMS-1:0]                      = elem_s;
          dat_nxt[`BGM_ELEM_MUTE_LSB +: BGM_ELEMS]    = mute_r;
        end
        ADR_W'(`BGM_REG_TRIPS):
          dat_nxt[15:0] = trips_r;
        default:
          dat_nxt = `BGM_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ack_r       <= 1'b0;
      dat_r       <= `BGM_RST_WORD;
      fault_set_r <= 1'b0;
    end
    else if (ce_in)
    begin
      ack_r       <= ack_nxt;
      dat_r       <= dat_nxt;
      fault_set_r <= fault_set_nxt;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;

endmodule // bgm_guard

// ==== test/bgm_guard_asserts.sv ====
// Port assertions for the beam guard muting control
`timescale 1ns/1ps

module bgm_guard_chk (
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               ce_in,
  input wire bgm_pkg::bgm_elem_t elem_clear_in,
  input wire logic               pedal_in,
  input wire logic               fold_stage_in,
  input wire logic               load_dropped_in,
  input wire logic               fault_in,
  input wire logic               safety_release_out,
  input wire logic               box_lamp_out,
  input wire logic               wb_cyc_in,
  input wire logic               wb_stb_in,
  input wire logic               wb_ack_out
);
  // ==========================================================================
  // Properties
  property p_rst;
    @(posedge clk_in) !rst_n_in && ce_in |=> !safety_release_out && !wb_ack_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  property p_ack;
    @(posedge clk_in) disable iff (!rst_n_in) wb_ack_out && ce_in |=> !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_ans;
    @(posedge clk_in) disable iff (!rst_n_in)
      wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out;
  endproperty
  a_ans: assert property (p_ans) else $error("bus request not answered");
  // Release needs a fresh pedal edge and dropped loads
  property p_go;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(safety_release_out) |->
      $past(pedal_in, 3) && !$past(pedal_in, 4) && $past(load_dropped_in, 3);
  endproperty
  a_go: assert property (p_go) else $error("release without cause");
  property p_free;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(safety_release_out) |->
      $past(elem_clear_in[0], 3) && $past(elem_clear_in[1], 3);
  endproperty
  a_free: assert property (p_free) else $error("release with line beam cut");
  property p_cut;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!fold_stage_in && !elem_clear_in[0]) [*3] |-> ##1 !safety_release_out;
  endproperty
  a_cut: assert property (p_cut) else $error("cut beam kept release");
  property p_lamp;
    @(posedge clk_in) disable iff (!rst_n_in) $rose(box_lamp_out) |-> !safety_release_out;
  endproperty
  a_lamp: assert property (p_lamp) else $error("box armed mid stroke");
  property p_cancel;
    @(posedge clk_in) disable iff (!rst_n_in) $fell(box_lamp_out) |-> !safety_release_out;
  endproperty
  a_cancel: assert property (p_cancel) else $error("box dropped mid stroke");
  property p_fault;
    @(posedge clk_in) disable iff (!rst_n_in) fault_in |-> ##3 (!safety_release_out) [*4];
  endproperty
  a_fault: assert property (p_fault) else $error("release during fault");
endmodule // bgm_guard_chk

bind bgm_guard bgm_guard_chk chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .elem_clear_in(elem_clear_in), .pedal_in(pedal_in), .fold_stage_in(fold_stage_in),
  .load_dropped_in(load_dropped_in), .fault_in(fault_in),
  .safety_release_out(safety_release_out), .box_lamp_out(box_lamp_out),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out));

// ==== test/bgm_machine.sv ====
// Machine control model: pedal, box button, fold stage, start, load feedback
`timescale 1ns/1ps

module bgm_machine (
  input  wire logic clk_in,
  output logic      pedal_out,
  output logic      button_out,
  output logic      fold_out,
  output logic      start_out,
  output logic      dropped_out
);
  // ==========================================================================
  // Levels held five cycles, long enough to cross the synchroniser
  // Slow speed in box mode is a drive matter, not seen at these pins
  initial
  begin
    {pedal_out, button_out, fold_out, start_out, dropped_out} = 5'h01;
  end
  task automatic put(input logic [4:0] v);
    @(posedge clk_in);
    {pedal_out, button_out, fold_out, start_out, dropped_out} <= v;
    repeat (4) @(posedge clk_in);
  endtask
  // Start entry closed then opened
  task automatic start_cycle();
    put(5'h03);
    put(5'h01);
  endtask
endmodule // bgm_machine

// ==== test/bgm_guard_test.sv ====
// Self-checking bench for the beam guard muting control
`timescale 1ns/1ps

module bgm_guard_test;
  import bgm_pkg::*;
  logic clk_in, rst_n_in, fault_in, cyc, stb, we, ack, rel, lamp, ce;
  logic pedal, button, fold, start, dropped;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  bgm_elem_t elem;
  int bad_count, cmp_count, ticks;

  bgm_machine mc (.clk_in(clk_in), .pedal_out(pedal), .button_out(button),
    .fold_out(fold), .start_out(start), .dropped_out(dropped));
  bgm_guard uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .elem_clear_in(elem), .pedal_in(pedal), .box_button_in(button),
    .fold_stage_in(fold), .start_in(start), .load_dropped_in(dropped),
    .fault_in(fault_in), .safety_release_out(rel), .box_lamp_out(lamp),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));

  // ==========================================================================
  // Clock, timeout, shared tasks
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until ack; no fixed latency assumed
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_in); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic put_elem(input bgm_elem_t e);
    @(posedge clk_in);
    elem <= e;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios; model vector is {pedal, button, fold, start, dropped}
  task automatic s_lock();
    mc.put(5'h11);
    chk("lock", 1'b0, rel);
    wb(1'b0, 4'h4, 32'h0);
    chk("status", 32'h0000_0108, q);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    mc.put(5'h01);
    mc.start_cycle();
  endtask
  task automatic s_flat();
    mc.put(5'h11);
    chk("go", 1'b1, rel);
    wb(1'b0, 4'h8, 32'h0);
    chk("mute adj", 32'h0000_101F, q);
    mc.put(5'h15);
    wb(1'b0, 4'h8, 32'h0);
    chk("mute all", 32'h0000_1F1F, q);
    mc.put(5'h01);
    wb(1'b0, 4'h8, 32'h0);
    chk("mute end", 32'h0000_001F, q);
  endtask
  task automatic s_refuse();
    ce <= 1'b0;
    mc.put(5'h11);
    chk("frozen", 1'b0, rel);
    mc.put(5'h01);
    ce <= 1'b1;
    put_elem(5'h0F);
    mc.put(5'h11);
    chk("adj cut", 1'b0, rel);
    mc.put(5'h01);
    put_elem(5'h1F);
    mc.put(5'h10);
    mc.put(5'h11);
    chk("no drop", 1'b0, rel);
    mc.put(5'h01);
    sel <= 4'hE;
    wb(1'b1, 4'h0, 32'h1);
    sel <= 4'hF;
    chk("sel gate", 1'b0, lamp);
  endtask
  task automatic s_trip();
    mc.put(5'h11);
    put_elem(5'h1E);
    chk("trip", 1'b0, rel);
    put_elem(5'h1F);
    chk("stay", 1'b0, rel);
    mc.put(5'h01);
    mc.put(5'h11);
    chk("relock", 1'b0, rel);
    mc.put(5'h01);
    mc.start_cycle();
    wb(1'b0, 4'hC, 32'h0);
    chk("trips", 32'h1, q);
  endtask
  task automatic s_box();
    mc.put(5'h09);
    mc.put(5'h01);
    chk("lamp", 1'b1, lamp);
    put_elem(5'h03);
    mc.put(5'h11);
    chk("box go", 1'b1, rel);
    mc.put(5'h15);
    mc.put(5'h01);
    chk("cancel", 1'b0, lamp);
    put_elem(5'h1F);
    wb(1'b1, 4'h0, 32'h1);
    mc.put(5'h11);
    put_elem(5'h1D);
    chk("line cut", 1'b0, rel);
    chk("kept", 1'b1, lamp);
    put_elem(5'h1F);
    mc.put(5'h01);
    mc.start_cycle();
  endtask
  task automatic s_fault();
    @(posedge clk_in);
    fault_in <= 1'b1;
    mc.put(5'h11);
    chk("fault", 1'b0, rel);
    wb(1'b0, 4'h4, 32'h0);
    chk("fault bit", 1'b1, q[2]);
  endtask

  initial
  begin
    {rst_n_in, fault_in, cyc, stb, we, adr, wdat} = '0;
    elem = 5'h1F;
    ce = 1'b1;
    sel = 4'hF;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    s_lock();
    s_flat();
    s_refuse();
    s_trip();
    s_box();
    s_fault();
    report_and_stop();
  end
endmodule // bgm_guard_test
